// ==== inc/ioad_pkg.sv ====
// Package for the I/O module address decoder: constants and carrier structs
package ioad_pkg;
    localparam int            IOAD_ADDR_W    = 8;
    localparam int            IOAD_DATA_W    = 8;
    localparam int            IOAD_MAX_BYTES = 4;
    localparam logic [7:0]    IOAD_FIXED_IN  = 8'h00;  // Value read while enable is off
    localparam logic [7:0]    IOAD_OUT_RST   = 8'h00;  // Output byte value after reset
    localparam logic          IOAD_DIR_IN    = 1'b0;
    localparam logic          IOAD_DIR_OUT   = 1'b1;

    // Backplane request as seen by the module
    typedef struct packed {
        logic [7:0] byte_address_line;
        logic       bus_read_strobe_n;
        logic       bus_write_strobe_n;
        logic [7:0] wdata;
    } ioad_req_s;

    // Backplane answer from the module
    typedef struct packed {
        logic [7:0] rdata;
        logic       rdata_oe;
        logic       ready;
        logic       ack_timeout_fault;
    } ioad_rsp_s;

    typedef enum logic [1:0] {
        IOAD_IDLE,
        IOAD_ACK,
        IOAD_WAIT_RELEASE
    } ioad_state_e;
endpackage

// ==== design/ioad_byte_store.sv ====
// Small register store holding the module's output bytes
`timescale 1ns/1ps
module ioad_byte_store #(
    parameter int NBYTES = 4
) (
    clk,
    sys_rst,
    wr_en,
    wr_idx,
    wr_data,
    bytes_out
);
    import ioad_pkg::*;
    input  wire logic                          clk;
    input  wire logic                          sys_rst;
    input  wire logic                          wr_en;
    input  wire logic [1:0]                    wr_idx;
    input  wire logic [7:0]                    wr_data;
    output      logic [NBYTES*8-1:0]           bytes_out;

    logic [NBYTES*8-1:0] store_r;
    logic [NBYTES*8-1:0] store_nxt;

    // Next value: replace only the addressed byte
    always_comb begin
        store_nxt = store_r;
        if (wr_en) begin
            store_nxt[wr_idx*8 +: 8] = wr_data;
        end
    end

    // Register the store
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            store_r <= {NBYTES{IOAD_OUT_RST}};
        end else begin
            store_r <= store_nxt;
        end
    end

    assign bytes_out = store_r;
endmodule

// ==== design/ioad_decoder.sv ====
// Address decoder and byte access logic of a digital I/O backplane module
// Function
// - Base address is the weighted sum of eight switch toggles, 0 to 255.
// - Decoding uses only the switch setting, never the slot position.
// - Switches set only the first byte; further bytes follow consecutively.
// - Decode every address from base to base plus byte count minus one.
// - Input modules answer reads only; output modules answer writes only.
// - Enable off signals acknowledge-delay fault and reads a fixed value.
`timescale 1ns/1ps
module ioad_decoder #(
    parameter int   NBYTES = 1,
    parameter logic DIR    = ioad_pkg::IOAD_DIR_IN
) (
    clk,
    sys_rst,
    addr_switch,
    module_enable,
    req,
    rsp,
    input_bytes,
    output_bytes
);
    import ioad_pkg::*;
    input  wire logic                    clk;
    input  wire logic                    sys_rst;
    input  wire logic [7:0]              addr_switch;   // Toggle weights 128..1
    input  wire logic                    module_enable;
    input  wire ioad_pkg::ioad_req_s     req;
    output      ioad_pkg::ioad_rsp_s     rsp;
    input  wire logic [NBYTES*8-1:0]     input_bytes;
    output      logic [NBYTES*8-1:0]     output_bytes;

    // Bus cycle walk, read side
    //   c0: read strobe low, address inside the window
    //   c0: selected input byte captured into the read register
    //   c1: ready high, data bus driven with the captured byte
    //   c2 onwards: ready, drive and byte stand unchanged
    //   cN: strobe high or address leaves the window
    //   cN+1: ready and drive drop, handler back in idle
    // Bus cycle walk, write side
    //   c0: write strobe low, address inside the window
    //   c0: data byte latched once into its output slot
    //   c1: ready high, output byte already updated
    //   cN+1: ready drops after the strobe goes away
    // Disabled module
    //   No ready is ever given; the CPU's own watchdog ends it
    //   Fault level stands while the module stays addressed
    //   Reads see the fixed value, writes land nowhere
    //   Fault drops one cycle after the strobe goes away
    // Window
    //   Base is the switch value, first byte at the base
    //   Further bytes at base plus one, two and three
    //   Nine bit offset: an address below base never matches
    //   So a window near 255 never wraps round to address 0
    // Direction
    //   Input modules look only at the read strobe
    //   Output modules look only at the write strobe
    //   Input and output modules may share a base safely
    // Limitations
    //   One sample per strobe: the CPU must release between cycles
    //   Address moves inside the window while strobed are ignored
    //   Enable changes take effect on the next strobe only
    //   Input bytes are sampled once, not tracked during the cycle

    ioad_state_e state_r;
    ioad_state_e state_nxt;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    logic        oe_r;
    logic        oe_nxt;
    logic        fault_r;
    logic        fault_nxt;
    logic [8:0]  offset;
    logic        in_range;
    logic        strobe_ok;
    logic        hit;
    logic [1:0]  byte_idx;
    logic        wr_en;
    logic        take_on;
    logic        take_off;

    // Offset from base; switch value is the base, no slot input exists
    assign offset   = {1'b0, req.byte_address_line} - {1'b0, addr_switch};
    // Borrow bit set means address below base, so no wrap past 255
    assign in_range = (offset < 9'(NBYTES));
    assign byte_idx = offset[1:0];

    // Direction qualifies which strobe counts
    assign strobe_ok = (DIR == IOAD_DIR_IN) ? !req.bus_read_strobe_n
                                            : !req.bus_write_strobe_n;
    assign hit = in_range && strobe_ok;

    // Cycle entry, looked at only from idle so one strobe gives one sample
    assign take_on  = (state_r == IOAD_IDLE) && hit && module_enable;
    assign take_off = (state_r == IOAD_IDLE) && hit && !module_enable;

    // Write lands in the taking cycle, so the byte is updated with ready
    assign wr_en = take_on && (DIR == IOAD_DIR_OUT);

    // Next state of the bus cycle handler
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            IOAD_IDLE: begin
                if (take_on) begin
                    state_nxt = IOAD_ACK;
                end else if (take_off) begin
                    // No ready given; the CPU times out on its own
                    state_nxt = IOAD_WAIT_RELEASE;
                end
            end
            IOAD_ACK: begin
                // Ready held until the strobe goes away
                if (!hit) begin
                    state_nxt = IOAD_IDLE;
                end
            end
            IOAD_WAIT_RELEASE: begin
                // Disabled access stays parked until released
                if (!hit) begin
                    state_nxt = IOAD_IDLE;
                end
            end
            default: begin
                state_nxt = IOAD_IDLE;
            end
        endcase
    end

    // Register the bus cycle handler
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= IOAD_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Next read byte and drive; data captured once, at entry
    always_comb begin
        rdata_nxt = rdata_r;
        oe_nxt    = oe_r;
        if (take_on) begin
            if (DIR == IOAD_DIR_IN) begin
                rdata_nxt = input_bytes[byte_idx*8 +: 8];
            end
            oe_nxt = (DIR == IOAD_DIR_IN);
        end else if (take_off) begin
            rdata_nxt = IOAD_FIXED_IN;
            oe_nxt    = (DIR == IOAD_DIR_IN);
        end else if ((state_r == IOAD_IDLE) || !hit) begin
            // Drive released one cycle after the strobe
            oe_nxt = 1'b0;
        end
    end

    // Register the read byte and its drive enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
            oe_r    <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // Next fault level: set on a disabled access, held while addressed
    always_comb begin
        fault_nxt = 1'b0;
        if (take_off) begin
            fault_nxt = 1'b1;
        end else if (state_r == IOAD_WAIT_RELEASE) begin
            fault_nxt = hit;
        end
    end

    // Register the fault level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
        end
    end

    // Output byte storage, one slot per decoded address
    ioad_byte_store #(
        .NBYTES (NBYTES)
    ) u_store (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .wr_en     (wr_en),
        .wr_idx    (byte_idx),
        .wr_data   (req.wdata),
        .bytes_out (output_bytes)
    );

    // Answer to the backplane
    always_comb begin
        rsp.rdata             = rdata_r;
        rsp.rdata_oe          = oe_r;
        rsp.ready             = (state_r == IOAD_ACK);
        rsp.ack_timeout_fault = fault_r;
    end
endmodule

// ==== sim/ioad_decoder_asserts.sv ====
// Port checker for the address decoder
`timescale 1ns/1ps
module ioad_decoder_asserts
    import ioad_pkg::*;
#(
    parameter int   NBYTES = 1,
    parameter logic DIR    = 1'b0
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic [7:0]            addr_switch,
    input wire logic                  module_enable,
    input wire ioad_pkg::ioad_req_s   req,
    input wire ioad_pkg::ioad_rsp_s   rsp,
    input wire logic [NBYTES*8-1:0]   input_bytes,
    input wire logic [NBYTES*8-1:0]   output_bytes
);
    // Offset from the switch base; 9 bits so no wrap past 255
    wire logic [8:0] ofs = {1'b0, req.byte_address_line}
                         - {1'b0, addr_switch};
    wire logic hit = !(DIR ? req.bus_write_strobe_n : req.bus_read_strobe_n)
                     && (ofs < 9'(NBYTES));
    wire logic on = hit && module_enable;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ready_hit_a: assert property (
        on |=> rsp.ready && !rsp.ack_timeout_fault)
        else $error("no ready");
    fault_off_a: assert property (
        hit && !module_enable |=> rsp.ack_timeout_fault && !rsp.ready)
        else $error("no fault");
    quiet_miss_a: assert property (
        !hit |=> !rsp.ready && !rsp.ack_timeout_fault && !rsp.rdata_oe)
        else $error("stray");
    read_byte_a: assert property (
        on && !DIR |=> rsp.rdata_oe
            && rsp.rdata == 8'($past(input_bytes) >> (8 * $past(ofs))))
        else $error("rdata");
    read_fixed_a: assert property (
        hit && !module_enable && !DIR |=> rsp.rdata == IOAD_FIXED_IN)
        else $error("fixed");
    out_no_oe_a: assert property (
        DIR |-> !rsp.rdata_oe)
        else $error("oe");
    write_latch_a: assert property (
        on && DIR |=> 8'(output_bytes >> (8 * $past(ofs))) == $past(req.wdata))
        else $error("wr");
    out_hold_a: assert property (
        !on |=> $stable(output_bytes))
        else $error("hold");
endmodule
bind ioad_decoder ioad_decoder_asserts #(.NBYTES(NBYTES), .DIR(DIR)) chk (.clk(clk),
    .sys_rst(sys_rst), .addr_switch(addr_switch), .module_enable(module_enable), .req(req),
    .rsp(rsp), .input_bytes(input_bytes), .output_bytes(output_bytes));

// ==== sim/ioad_cpu_model.sv ====
// Controller CPU model driving backplane cycles
`timescale 1ns/1ps
module ioad_cpu_model (
    input wire logic clk,
    input wire ioad_pkg::ioad_rsp_s rsp,
    output ioad_pkg::ioad_req_s req
);
    // Idle bus: strobes high, lines parked off any real value
    initial req = '{8'h5A, 1'b1, 1'b1, 8'hA5};
    // Held until the answer edge, then released and one idle cycle
    task automatic access(input logic [7:0] a, input logic rd, input logic [7:0] d,
        output logic [7:0] q, output logic ack);
        @(negedge clk) req = '{a, !rd, rd, d};
        repeat (2) @(posedge clk);
        ack = rsp.ready | rsp.ack_timeout_fault;
        q = rsp.rdata;
        @(negedge clk) req = '{~a, 1'b1, 1'b1, ~d};
        @(negedge clk);
    endtask
endmodule

// ==== sim/io_module_address_decoder_tb_top.sv ====
// Bench for the I/O address decoder
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t bad", $time); end end
module io_module_address_decoder_tb_top;
    import ioad_pkg::*;
    logic clk = 0, sys_rst = 1, module_enable = 1, ack;
    logic [7:0] addr_switch = 8'h14, q;
    logic [31:0] in_b = 32'h44332211;
    logic [15:0] out_b;
    int bad_count = 0, checks = 0, cyc = 0;
    ioad_req_s req;
    ioad_rsp_s rsp_i, rsp_o;
    ioad_cpu_model cpu (.clk(clk), .rsp(req.bus_read_strobe_n ? rsp_o : rsp_i), .req(req));
    ioad_decoder #(.NBYTES(4), .DIR(IOAD_DIR_IN)) uut (.clk(clk), .sys_rst(sys_rst),
        .addr_switch(addr_switch), .module_enable(module_enable), .req(req), .rsp(rsp_i),
        .input_bytes(in_b), .output_bytes());
    ioad_decoder #(.NBYTES(2), .DIR(IOAD_DIR_OUT)) uut_out (.clk(clk), .sys_rst(sys_rst),
        .addr_switch(addr_switch), .module_enable(module_enable), .req(req), .rsp(rsp_o),
        .input_bytes(16'h0000), .output_bytes(out_b));
    // Clock and hang guard; the run needs about 68 cycles
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 900) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reads 19..24 around the four-byte window
    task automatic t_read();
        for (int k = 0; k < 6; k++) begin
            cpu.access(8'(19 + k), 1, 8'h00, q, ack);
            `CHK(ack, k inside {[1:4]})
            if (ack === 1'b1) `CHK(q, 8'(in_b >> (8 * k - 8)))
        end
        `CHK(out_b, 16'h0000)
    endtask
    // Two-byte output module, third byte refused
    task automatic t_write();
        cpu.access(8'h14, 0, 8'h5C, q, ack);
        cpu.access(8'h15, 0, 8'hC5, q, ack);
        cpu.access(8'h16, 0, 8'hFF, q, ack);
        `CHK({ack, out_b}, 17'h0C55C)
    endtask
    // Disabled: fault, fixed read value, no write
    task automatic t_off();
        module_enable = 0;
        cpu.access(8'h15, 1, 8'h00, q, ack);
        `CHK({ack, q}, {1'b1, IOAD_FIXED_IN})
        cpu.access(8'h14, 0, 8'h00, q, ack);
        `CHK(out_b, 16'hC55C)
        module_enable = 1;
    endtask
    // Base 23 from weights, then 255 with no wrap to 0
    task automatic t_top();
        addr_switch = 8'h17;
        cpu.access(8'h17, 1, 8'h00, q, ack);
        `CHK({ack, q}, 9'h111)
        addr_switch = 8'hFF;
        cpu.access(8'h00, 1, 8'h00, q, ack);
        `CHK(ack, 1'b0)
    endtask
    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 0;
        t_read();
        t_write();
        t_off();
        t_top();
        close_out();
    end
endmodule
